// ---- tdc_pkg.sv ----
// Shared constants and types for the dual 8-bit timer control block
package tdc_pkg;

  // Register byte addresses
  localparam logic [15:0] TDC_ADDR_PORT3_DIR = 16'hff23;
  localparam logic [15:0] TDC_ADDR_PORT9_DIR = 16'hff29;
  localparam logic [15:0] TDC_ADDR_MODE_A = 16'hff70;
  localparam logic [15:0] TDC_ADDR_CLKSEL_A = 16'hff71;
  localparam logic [15:0] TDC_ADDR_MODE_B = 16'hff74;
  localparam logic [15:0] TDC_ADDR_CLKSEL_B = 16'hff75;
  localparam logic [15:0] TDC_ADDR_COUNT_A = 16'hff80;
  localparam logic [15:0] TDC_ADDR_COUNT_B = 16'hff81;
  localparam logic [15:0] TDC_ADDR_COMPARE_A = 16'hff82;
  localparam logic [15:0] TDC_ADDR_COMPARE_B = 16'hff83;

  // Reset values
  localparam logic [7:0] TDC_RST_MODE = 8'h00;
  localparam logic [2:0] TDC_RST_CLKSEL = 3'h0;
  localparam logic [7:0] TDC_RST_COMPARE = 8'h00;
  localparam logic [7:0] TDC_RST_COUNT = 8'h00;
  localparam logic [7:0] TDC_RST_PORT9_DIR = 8'hff;
  localparam logic [3:0] TDC_RST_PORT3_DIR_HI = 4'hf;
  localparam logic [3:0] TDC_PORT3_DIR_LO_FIXED = 4'hf;
  localparam logic [7:0] TDC_READ_UNMAPPED = 8'h00;

  // Mode control field positions
  localparam int TDC_MODE_RUN = 7;
  localparam int TDC_MODE_PWM = 6;
  localparam int TDC_MODE_CASCADE = 4;
  localparam int TDC_MODE_FF_SET = 3;
  localparam int TDC_MODE_FF_RESET = 2;
  localparam int TDC_MODE_INV = 1;
  localparam int TDC_MODE_OUT_EN = 0;

  // Timer pins inside the two ports
  localparam int TDC_PORT3_TIMER_PIN = 4;
  localparam int TDC_PORT9_TIMER_PIN = 1;

  // Clock select codes
  localparam logic [2:0] TDC_SEL_EXT_FALL = 3'h0;
  localparam logic [2:0] TDC_SEL_EXT_RISE = 3'h1;

  // Divider exponents per select code, index 0 and 1 unused (external)
  localparam logic [7:0][3:0] TDC_DIV_TAB_A = {4'hb, 4'h9, 4'h8, 4'h7, 4'h5, 4'h3, 4'h0, 4'h0};
  localparam logic [7:0][3:0] TDC_DIV_TAB_B = {4'hc, 4'ha, 4'h8, 4'h7, 4'h6, 4'h4, 4'h0, 4'h0};
  localparam int TDC_PRESCALE_W = 12;
  localparam logic [TDC_PRESCALE_W-1:0] TDC_PRESCALE_ONE = 12'h001;

  localparam logic [7:0] TDC_COUNT_MAX = 8'hff;
  localparam logic [7:0] TDC_COUNT_ZERO = 8'h00;

  // Stored mode control fields
  typedef struct packed {
    logic run;
    logic pwm;
    logic cascade;
    logic inv;
    logic outEn;
  } tdc_mode_s;

  // Processor access: byte write, single-bit write or read
  typedef struct packed {
    logic wr;
    logic bitWr;
    logic rd;
    logic [15:0] addr;
    logic [2:0] bitIdx;
    logic bitVal;
    logic [7:0] wdata;
  } tdc_cpu_req_s;

endpackage

// ---- tdc_clk_sel.sv ----
// Count-clock selector: prescaler taps and synchronised external edge
`timescale 1ns/10ps
`default_nettype none
module tdc_clk_sel
  import tdc_pkg::*;
#(
  parameter logic [7:0][3:0] DIV_TAB = TDC_DIV_TAB_A
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Control
  input wire logic [2:0] sel,
  // Event pin
  input wire logic eventPin,
  // Count tick
  output logic tick,
  output logic extSel
);

  logic [TDC_PRESCALE_W-1:0] pre_r;
  logic [TDC_PRESCALE_W-1:0] tapMask;
  logic [3:0] divExp;
  logic syncA_r;
  logic syncB_r;
  logic prev_r;
  logic edgeHit;
  logic tapHit;
  logic tick_r;

  assign divExp = DIV_TAB[sel];
  // At exponent 12 the shift wraps to zero and the mask becomes all ones
  assign tapMask = (TDC_PRESCALE_ONE << divExp) - TDC_PRESCALE_ONE;
  assign tapHit = (pre_r & tapMask) == tapMask;
  assign extSel = (sel == TDC_SEL_EXT_FALL) || (sel == TDC_SEL_EXT_RISE);
  assign edgeHit = (sel == TDC_SEL_EXT_FALL) ? (prev_r & ~syncB_r) : (~prev_r & syncB_r);
  assign tick = tick_r;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pre_r <= '0;
      syncA_r <= 1'b0;
      syncB_r <= 1'b0;
      prev_r <= 1'b0;
      tick_r <= 1'b0;
    end else begin
      pre_r <= pre_r + TDC_PRESCALE_ONE;
      syncA_r <= eventPin;
      syncB_r <= syncA_r;
      prev_r <= syncB_r;
      tick_r <= extSel ? edgeHit : tapHit;
    end
  end

endmodule
`default_nettype wire

// ---- tdc_channel.sv ----
// One 8-bit counter with compare match and output flip-flop
`timescale 1ns/10ps
`default_nettype none
module tdc_channel
  import tdc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Control
  input wire tdc_mode_s ctrl,
  input wire logic cntEn,
  input wire logic matchHit,
  input wire logic ffSetStb,
  input wire logic ffRstStb,
  input wire logic [7:0] compare,
  // Status
  output logic [7:0] count,
  output logic eqCmp,
  output logic atMax,
  output logic timerOut,
  output logic matchIrq
);

  logic [7:0] count_r;
  logic [7:0] count_nxt;
  logic ff_r;
  logic ff_nxt;
  logic pwmLvl_r;
  logic out_r;
  logic irq_r;
  logic hit;

  assign eqCmp = count_r == compare;
  assign atMax = count_r == TDC_COUNT_MAX;
  assign hit = ctrl.run & cntEn & matchHit;
  assign count = count_r;
  assign timerOut = out_r;
  assign matchIrq = irq_r;

  always_comb begin
    if (!ctrl.run) begin
      count_nxt = TDC_COUNT_ZERO;
    end else if (!cntEn) begin
      count_nxt = count_r;
    end else if (matchHit && !ctrl.pwm) begin
      count_nxt = TDC_COUNT_ZERO;
    end else begin
      count_nxt = count_r + 8'h01;
    end
  end

  // Software strobes win over a toggle in the same cycle
  always_comb begin
    if (ffSetStb) begin
      ff_nxt = 1'b1;
    end else if (ffRstStb) begin
      ff_nxt = 1'b0;
    end else if (hit && ctrl.inv && !ctrl.pwm) begin
      ff_nxt = ~ff_r;
    end else begin
      ff_nxt = ff_r;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      count_r <= TDC_RST_COUNT;
      ff_r <= 1'b0;
      pwmLvl_r <= 1'b0;
      out_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      ff_r <= ff_nxt;
      pwmLvl_r <= ctrl.run & (count_r < compare);
      out_r <= ctrl.pwm ? (pwmLvl_r ^ ctrl.inv) : ff_r;
      irq_r <= hit;
    end
  end

endmodule
`default_nettype wire

// ---- tdc_top.sv ----
// Dual 8-bit timer/event counter control with registers and timer pins
// How it works
// - Counter B clock select resets to zero; 3-bit read/write field.
// - Codes 000 and 001 count falling or rising edges of B's pin.
// - No timer or PWM output while a counter uses its external pin.
// - Mode registers reset to zero, accept bit and byte writes.
// - Mode bit 0 enables timer output; zero leaves port mode.
// - Mode bit 1 picks PWM active level or match inversion enable.
// - Set/reset pair: 00 no change, 01 clear, 10 set flip-flop.
// - Set and reset bits are strobes and always read zero.
// - Mode bit 6 picks clear-on-match or free-running PWM.
// - Mode bit 7 runs counter; zero stops and clears count.
// - Mode B bit 4 joins both counters into one 16-bit counter.
// - Direction bit 0 drives pin, 1 makes input; reset all ones.
// - Port 3 direction low four bits are fixed at one.
// - Clear mode match clears count, keeps counting, raises interrupt.
// - Compare registers are byte-written, full range, reset to zero.
// - Inversion outside PWM toggles output flip-flop on every match.
`timescale 1ns/10ps
`default_nettype none
module tdc_top
  import tdc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Processor register access
  input wire tdc_cpu_req_s cpuReq,
  output logic [7:0] cpuRdata,
  // Port output latches for the shared timer pins
  input wire logic port3Pin4Latch,
  input wire logic port9Pin1Latch,
  // Shared pin of counter A
  input wire logic counterAEventIn,
  output logic port3Pin4Out,
  output logic port3Pin4Oe,
  // Shared pin of counter B
  input wire logic counterBEventIn,
  output logic port9Pin1Out,
  output logic port9Pin1Oe,
  // Direction registers for the rest of both ports
  output logic [7:0] port3Dir,
  output logic [7:0] port9Dir,
  // Match interrupts
  output logic counterAMatchIrq,
  output logic counterBMatchIrq
);

  // Bit write folds into a byte update; byte write replaces the whole value
  function automatic logic [7:0] mergeWr(input logic [7:0] cur, input tdc_cpu_req_s req);
    logic [7:0] res;
    res = cur;
    if (req.wr) begin
      res = req.wdata;
    end else if (req.bitWr) begin
      res[req.bitIdx] = req.bitVal;
    end
    return res;
  endfunction

  function automatic tdc_mode_s toMode(input logic [7:0] v, input logic allowCascade);
    tdc_mode_s m;
    m.run = v[TDC_MODE_RUN];
    m.pwm = v[TDC_MODE_PWM];
    m.cascade = v[TDC_MODE_CASCADE] & allowCascade;
    m.inv = v[TDC_MODE_INV];
    m.outEn = v[TDC_MODE_OUT_EN];
    return m;
  endfunction

  function automatic logic [7:0] fromMode(input tdc_mode_s m);
    logic [7:0] v;
    v = 8'h00;
    v[TDC_MODE_RUN] = m.run;
    v[TDC_MODE_PWM] = m.pwm;
    v[TDC_MODE_CASCADE] = m.cascade;
    v[TDC_MODE_INV] = m.inv;
    v[TDC_MODE_OUT_EN] = m.outEn;
    return v;
  endfunction

  // Registers
  tdc_mode_s modeA_r;
  tdc_mode_s modeB_r;
  logic [2:0] clkSelA_r;
  logic [2:0] clkSelB_r;
  logic [7:0] compareA_r;
  logic [7:0] compareB_r;
  logic [7:4] port3DirHi_r;
  logic [7:0] port9Dir_r;
  logic [7:0] cpuRdata_r;
  logic port3Pin4Out_r;
  logic port3Pin4Oe_r;
  logic port9Pin1Out_r;
  logic port9Pin1Oe_r;

  // Decode
  logic anyWr;
  logic hitModeA;
  logic hitModeB;
  logic hitClkA;
  logic hitClkB;
  logic hitCmpA;
  logic hitCmpB;
  logic hitDir3;
  logic hitDir9;
  logic [7:0] modeAByte;
  logic [7:0] modeBByte;
  logic [7:0] port3DirByte;
  logic [7:0] wrModeA;
  logic [7:0] wrModeB;
  logic [7:0] wrClkA;
  logic [7:0] wrClkB;
  logic [7:0] wrDir3;
  logic [7:0] wrDir9;
  logic [7:0] readMux;
  logic setStbA;
  logic rstStbA;
  logic setStbB;
  logic rstStbB;

  // Counter datapath
  logic tickA;
  logic tickB;
  logic extA;
  logic extB;
  logic [7:0] countA;
  logic [7:0] countB;
  logic eqA;
  logic eqB;
  logic maxA;
  logic maxB;
  logic outA;
  logic outB;
  logic cascade;
  logic match16;
  logic matchA;
  logic matchB;
  logic cntEnB;
  tdc_mode_s modeBEff;
  logic driveA;
  logic driveB;

  assign anyWr = cpuReq.wr | cpuReq.bitWr;
  assign hitModeA = cpuReq.addr == TDC_ADDR_MODE_A;
  assign hitModeB = cpuReq.addr == TDC_ADDR_MODE_B;
  assign hitClkA = cpuReq.addr == TDC_ADDR_CLKSEL_A;
  assign hitClkB = cpuReq.addr == TDC_ADDR_CLKSEL_B;
  assign hitCmpA = cpuReq.addr == TDC_ADDR_COMPARE_A;
  assign hitCmpB = cpuReq.addr == TDC_ADDR_COMPARE_B;
  assign hitDir3 = cpuReq.addr == TDC_ADDR_PORT3_DIR;
  assign hitDir9 = cpuReq.addr == TDC_ADDR_PORT9_DIR;

  // Strobe bits are never stored, so they read back as zero
  assign modeAByte = fromMode(modeA_r);
  assign modeBByte = fromMode(modeB_r);
  assign port3DirByte = {port3DirHi_r, TDC_PORT3_DIR_LO_FIXED};

  assign wrModeA = mergeWr(modeAByte, cpuReq);
  assign wrModeB = mergeWr(modeBByte, cpuReq);
  assign wrClkA = mergeWr({5'h00, clkSelA_r}, cpuReq);
  assign wrClkB = mergeWr({5'h00, clkSelB_r}, cpuReq);
  assign wrDir3 = mergeWr(port3DirByte, cpuReq);
  assign wrDir9 = mergeWr(port9Dir_r, cpuReq);

  // Code 11 is prohibited and gives neither strobe
  assign setStbA = hitModeA & anyWr & wrModeA[TDC_MODE_FF_SET] & ~wrModeA[TDC_MODE_FF_RESET];
  assign rstStbA = hitModeA & anyWr & wrModeA[TDC_MODE_FF_RESET] & ~wrModeA[TDC_MODE_FF_SET];
  assign setStbB = hitModeB & anyWr & wrModeB[TDC_MODE_FF_SET] & ~wrModeB[TDC_MODE_FF_RESET];
  assign rstStbB = hitModeB & anyWr & wrModeB[TDC_MODE_FF_RESET] & ~wrModeB[TDC_MODE_FF_SET];

  assign readMux = hitModeA ? modeAByte :
                   hitModeB ? modeBByte :
                   hitClkA ? {5'h00, clkSelA_r} :
                   hitClkB ? {5'h00, clkSelB_r} :
                   hitCmpA ? compareA_r :
                   hitCmpB ? compareB_r :
                   hitDir3 ? port3DirByte :
                   hitDir9 ? port9Dir_r :
                   cpuReq.addr == TDC_ADDR_COUNT_A ? countA :
                   cpuReq.addr == TDC_ADDR_COUNT_B ? countB :
                   TDC_READ_UNMAPPED;

  // Cascade: A wraps freely, B steps on A's carry, both clear on the 16-bit match
  assign cascade = modeB_r.cascade;
  assign match16 = eqA & eqB;
  assign matchA = cascade ? match16 : eqA;
  assign matchB = cascade ? match16 : eqB;
  assign cntEnB = cascade ? (tickA & (maxA | match16)) : tickB;
  // Stopping A also stops and clears the joined upper byte
  assign modeBEff = cascade ? tdc_mode_s'{run: modeA_r.run, pwm: 1'b0, cascade: 1'b1, inv: modeB_r.inv,
                                outEn: modeB_r.outEn} : modeB_r;

  // Timer drive only with output enabled and an internal count clock
  assign driveA = modeA_r.outEn & ~extA;
  assign driveB = modeB_r.outEn & ~extB & ~(cascade & extA);

  tdc_clk_sel #(
    .DIV_TAB(TDC_DIV_TAB_A)
  ) uClkA (
    .mclk(mclk),
    .nrst(nrst),
    .sel(clkSelA_r),
    .eventPin(counterAEventIn),
    .tick(tickA),
    .extSel(extA)
  );

  tdc_clk_sel #(
    .DIV_TAB(TDC_DIV_TAB_B)
  ) uClkB (
    .mclk(mclk),
    .nrst(nrst),
    .sel(clkSelB_r),
    .eventPin(counterBEventIn),
    .tick(tickB),
    .extSel(extB)
  );

  tdc_channel uChanA (
    .mclk(mclk),
    .nrst(nrst),
    .ctrl(modeA_r),
    .cntEn(tickA),
    .matchHit(matchA),
    .ffSetStb(setStbA),
    .ffRstStb(rstStbA),
    .compare(compareA_r),
    .count(countA),
    .eqCmp(eqA),
    .atMax(maxA),
    .timerOut(outA),
    .matchIrq(counterAMatchIrq)
  );

  tdc_channel uChanB (
    .mclk(mclk),
    .nrst(nrst),
    .ctrl(modeBEff),
    .cntEn(cntEnB),
    .matchHit(matchB),
    .ffSetStb(setStbB),
    .ffRstStb(rstStbB),
    .compare(compareB_r),
    .count(countB),
    .eqCmp(eqB),
    .atMax(maxB),
    .timerOut(outB),
    .matchIrq(counterBMatchIrq)
  );

  // Mode and clock select registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      modeA_r <= toMode(TDC_RST_MODE, 1'b0);
      modeB_r <= toMode(TDC_RST_MODE, 1'b1);
      clkSelA_r <= TDC_RST_CLKSEL;
      clkSelB_r <= TDC_RST_CLKSEL;
    end else begin
      if (hitModeA && anyWr) begin
        modeA_r <= toMode(wrModeA, 1'b0);
      end
      if (hitModeB && anyWr) begin
        modeB_r <= toMode(wrModeB, 1'b1);
      end
      if (hitClkA && anyWr) begin
        clkSelA_r <= wrClkA[2:0];
      end
      if (hitClkB && anyWr) begin
        clkSelB_r <= wrClkB[2:0];
      end
    end
  end

  // Compare registers take byte writes only
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      compareA_r <= TDC_RST_COMPARE;
      compareB_r <= TDC_RST_COMPARE;
    end else begin
      if (hitCmpA && cpuReq.wr) begin
        compareA_r <= cpuReq.wdata;
      end
      if (hitCmpB && cpuReq.wr) begin
        compareB_r <= cpuReq.wdata;
      end
    end
  end

  // Direction registers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      port3DirHi_r <= TDC_RST_PORT3_DIR_HI;
      port9Dir_r <= TDC_RST_PORT9_DIR;
    end else begin
      if (hitDir3 && anyWr) begin
        port3DirHi_r <= wrDir3[7:4];
      end
      if (hitDir9 && anyWr) begin
        port9Dir_r <= wrDir9;
      end
    end
  end

  // Read data and pin drive; the latch must be zero for the timer level to show
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cpuRdata_r <= TDC_READ_UNMAPPED;
      port3Pin4Out_r <= 1'b0;
      port3Pin4Oe_r <= 1'b0;
      port9Pin1Out_r <= 1'b0;
      port9Pin1Oe_r <= 1'b0;
    end else begin
      if (cpuReq.rd) begin
        cpuRdata_r <= readMux;
      end
      port3Pin4Out_r <= port3Pin4Latch | (driveA & outA);
      port3Pin4Oe_r <= ~port3DirHi_r[TDC_PORT3_TIMER_PIN];
      port9Pin1Out_r <= port9Pin1Latch | (driveB & outB);
      port9Pin1Oe_r <= ~port9Dir_r[TDC_PORT9_TIMER_PIN];
    end
  end

  assign cpuRdata = cpuRdata_r;
  assign port3Pin4Out = port3Pin4Out_r;
  assign port3Pin4Oe = port3Pin4Oe_r;
  assign port9Pin1Out = port9Pin1Out_r;
  assign port9Pin1Oe = port9Pin1Oe_r;
  assign port3Dir = port3DirByte;
  assign port9Dir = port9Dir_r;

endmodule
`default_nettype wire

// ---- tdc_checker.sv ----
// Port-level assertions for the dual timer control block
`timescale 1ns/10ps
`default_nettype none
module tdc_checker
  import tdc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Register access
  input wire tdc_cpu_req_s cpuReq,
  input wire logic [7:0] cpuRdata,
  // Timer pins
  input wire logic port3Pin4Latch,
  input wire logic port9Pin1Latch,
  input wire logic port3Pin4Out,
  input wire logic port3Pin4Oe,
  input wire logic port9Pin1Out,
  input wire logic port9Pin1Oe,
  input wire logic [7:0] port3Dir,
  input wire logic [7:0] port9Dir,
  // Interrupts
  input wire logic counterAMatchIrq,
  input wire logic counterBMatchIrq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  wire rdMode = cpuReq.rd && (cpuReq.addr == TDC_ADDR_MODE_A || cpuReq.addr == TDC_ADDR_MODE_B);
  wire rdSel = cpuReq.rd && cpuReq.addr == TDC_ADDR_CLKSEL_B;
  wire rdDir9 = cpuReq.rd && cpuReq.addr == TDC_ADDR_PORT9_DIR;

  a_dir_low_fixed: assert property (port3Dir[3:0] == 4'hf)
    else $error("port3 direction low nibble not all ones");
  a_oe_port3_dir: assert property (($stable(port3Dir[4]))[*2] |-> port3Pin4Oe == !port3Dir[4])
    else $error("port3 pin enable does not follow direction");
  a_oe_port9_dir: assert property (($stable(port9Dir[1]))[*2] |-> port9Pin1Oe == !port9Dir[1])
    else $error("port9 pin enable does not follow direction");
  a_latch_port3_pin: assert property (port3Pin4Latch |=> port3Pin4Out)
    else $error("port3 latch high but pin low");
  a_latch_port9_pin: assert property (port9Pin1Latch |=> port9Pin1Out)
    else $error("port9 latch high but pin low");
  a_irqa_one_cycle: assert property (counterAMatchIrq |=> !counterAMatchIrq)
    else $error("counter A interrupt longer than one cycle");
  a_irqb_one_cycle: assert property (counterBMatchIrq |=> !counterBMatchIrq)
    else $error("counter B interrupt longer than one cycle");
  a_strobe_reads_zero: assert property (rdMode |=> cpuRdata[3:2] == 2'h0)
    else $error("flip-flop strobe bits read nonzero");
  a_clksel_upper_zero: assert property (rdSel |=> cpuRdata[7:3] == 5'h00)
    else $error("clock select upper bits read nonzero");
  a_dir9_readback: assert property (rdDir9 |=> cpuRdata == $past(port9Dir))
    else $error("port9 direction read differs from register");
endmodule
bind tdc_top tdc_checker u_chk (.mclk(mclk), .nrst(nrst), .cpuReq(cpuReq), .cpuRdata(cpuRdata),
  .port3Pin4Latch(port3Pin4Latch), .port9Pin1Latch(port9Pin1Latch), .port3Pin4Out(port3Pin4Out),
  .port3Pin4Oe(port3Pin4Oe), .port9Pin1Out(port9Pin1Out), .port9Pin1Oe(port9Pin1Oe), .port3Dir(port3Dir),
  .port9Dir(port9Dir), .counterAMatchIrq(counterAMatchIrq), .counterBMatchIrq(counterBMatchIrq));
`default_nettype wire

// ---- tdc_pin_model.sv ----
// Event source standing at the two timer pins
`timescale 1ns/10ps
`default_nettype none
module tdc_pin_model (
  // Clock
  input wire logic mclk,
  // Event pins
  output logic evA,
  output logic evB
);
  // Each level held several clocks so the synchroniser never misses an edge
  task automatic pulse_b(input int n);
    repeat (n) begin
      repeat (2) begin
        @(negedge mclk);
        evB = ~evB;
        repeat (6) @(negedge mclk);
      end
    end
  endtask
  initial begin
    evA = 1'h0;
    evB = 1'h0;
  end
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Register-level testbench for the dual timer control block
`timescale 1ns/10ps
`default_nettype none
module testbench
  import tdc_pkg::*;
;
  logic mclk, nrst, p3Latch, p9Latch, evA, evB, p3Out, p3Oe, p9Out, p9Oe, irqA, irqB, v;
  tdc_cpu_req_s cpuReq;
  logic [7:0] cpuRdata, port3Dir, port9Dir;
  int n_fail, compares, irqBCnt, n, cnt;
  localparam int B_EXP [8] = '{0, 0, 4, 6, 7, 8, 10, 12};
  localparam logic [15:0] RA [8] = '{16'hff23, 16'hff29, 16'hff70, 16'hff74, 16'hff75, 16'hff82, 16'hff83, 16'hff81};
  localparam logic [7:0] RV [8] = '{8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic [15:0] WA [11] = '{16'hff75, 16'hff70, 16'hff70, 16'hff74, 16'hff74, 16'hff23, 16'hff29,
    16'hff80, 16'hff90, 16'hff82, 16'hff75};
  localparam logic [7:0] WD [11] = '{8'h07, 8'hcb, 8'h00, 8'hdb, 8'h00, 8'h00, 8'h5a, 8'h55, 8'h55, 8'ha5, 8'h00};
  localparam logic [7:0] WE [11] = '{8'h07, 8'hc3, 8'h00, 8'hd3, 8'h00, 8'h0f, 8'h5a, 8'h00, 8'h00, 8'ha5, 8'h00};

  tdc_top DUT (.mclk(mclk), .nrst(nrst), .cpuReq(cpuReq), .cpuRdata(cpuRdata), .port3Pin4Latch(p3Latch),
    .port9Pin1Latch(p9Latch), .counterAEventIn(evA), .port3Pin4Out(p3Out), .port3Pin4Oe(p3Oe),
    .counterBEventIn(evB), .port9Pin1Out(p9Out), .port9Pin1Oe(p9Oe), .port3Dir(port3Dir), .port9Dir(port9Dir),
    .counterAMatchIrq(irqA), .counterBMatchIrq(irqB));
  tdc_pin_model pins (.mclk(mclk), .evA(evA), .evB(evB));

  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end
  always @(negedge mclk) if (irqB === 1'h1) irqBCnt++;

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One access occupies one cycle; read data is settled by the following falling edge
  task automatic acc(input logic w, input logic b, input logic r, input logic [15:0] a, input logic [2:0] i,
    input logic [7:0] d);
    @(negedge mclk);
    cpuReq = '{wr: w, bitWr: b, rd: r, addr: a, bitIdx: i, bitVal: d[0], wdata: d};
    @(negedge mclk);
    cpuReq = '0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    acc(1'h1, 1'h0, 1'h0, a, 3'h0, d);
  endtask
  task automatic bwr(input logic [15:0] a, input logic [2:0] i, input logic b);
    acc(1'h0, 1'h1, 1'h0, a, i, {7'h00, b});
  endtask
  task automatic rd(input string name, input logic [15:0] a, input logic [7:0] e);
    acc(1'h0, 1'h0, 1'h1, a, 3'h0, 8'h00);
    chk(name, {8'h00, e}, {8'h00, cpuRdata});
  endtask
  task automatic wait_irq(input logic useA, output int k);
    k = 0;
    do begin
      @(negedge mclk);
      k++;
    end while ((useA ? irqA : irqB) !== 1'h1 && k < 10000);
    if (k >= 10000) chk("irq wait", 16'h0001, 16'h0000);
  endtask
  task automatic final_report;
    if (n_fail == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #400000;
    n_fail++;
    final_report();
  end

  initial begin
    cpuReq = '0;
    p3Latch = 1'h0;
    p9Latch = 1'h0;
    nrst = 1'h0;
    repeat (3) @(negedge mclk);
    nrst = 1'h1;
    chk("port3Dir", 16'h00ff, {8'h00, port3Dir});
    for (int k = 0; k < 8; k++) rd("reset value", RA[k], RV[k]);
    for (int k = 0; k < 11; k++) begin
      wr(WA[k], WD[k]);
      rd("write readback", WA[k], WE[k]);
    end
    bwr(TDC_ADDR_COMPARE_A, 3'h0, 1'h0);
    rd("compare bit write", TDC_ADDR_COMPARE_A, 8'ha5);
    bwr(TDC_ADDR_MODE_A, 3'h0, 1'h1);
    bwr(TDC_ADDR_MODE_A, 3'h3, 1'h1);
    bwr(TDC_ADDR_MODE_A, 3'h7, 1'h1);
    rd("mode bit writes", TDC_ADDR_MODE_A, 8'h81);
    wr(TDC_ADDR_MODE_A, 8'h00);
    bwr(TDC_ADDR_PORT9_DIR, 3'h1, 1'h0);
    wr(TDC_ADDR_MODE_B, 8'h01);
    bwr(TDC_ADDR_MODE_B, 3'h3, 1'h1);
    repeat (4) @(negedge mclk);
    chk("pin9 external clock", 16'h0000, {15'h0000, p9Out});
    chk("pin9 enable", 16'h0001, {15'h0000, p9Oe});
    wr(TDC_ADDR_CLKSEL_B, 8'h02);
    repeat (4) @(negedge mclk);
    chk("pin9 after set", 16'h0001, {15'h0000, p9Out});
    bwr(TDC_ADDR_MODE_B, 3'h2, 1'h1);
    repeat (4) @(negedge mclk);
    chk("pin9 after reset", 16'h0000, {15'h0000, p9Out});
    bwr(TDC_ADDR_MODE_B, 3'h0, 1'h0);
    bwr(TDC_ADDR_MODE_B, 3'h3, 1'h1);
    repeat (4) @(negedge mclk);
    chk("pin9 output off", 16'h0000, {15'h0000, p9Out});
    wr(TDC_ADDR_COMPARE_B, 8'h01);
    // Interval and square wave for every internal divider of counter B
    for (int c = 2; c < 8; c++) begin
      wr(TDC_ADDR_MODE_B, 8'h00);
      wr(TDC_ADDR_CLKSEL_B, 8'(c));
      wr(TDC_ADDR_MODE_B, 8'h83);
      wait_irq(1'h0, n);
      repeat (3) @(negedge mclk);
      v = p9Out;
      wait_irq(1'h0, n);
      chk("interval B", 16'(2 << B_EXP[c]), 16'(n + 3));
      repeat (3) @(negedge mclk);
      chk("square wave", {15'h0000, ~v}, {15'h0000, p9Out});
    end
    wr(TDC_ADDR_MODE_B, 8'h00);
    rd("stopped count", TDC_ADDR_COUNT_B, 8'h00);
    wr(TDC_ADDR_COMPARE_B, 8'h02);
    for (int c = 0; c < 2; c++) begin
      wr(TDC_ADDR_CLKSEL_B, 8'(c));
      wr(TDC_ADDR_MODE_B, 8'h80);
      cnt = irqBCnt;
      pins.pulse_b(2);
      chk("edges before match", 16'h0000, 16'(irqBCnt - cnt));
      pins.pulse_b(1);
      repeat (6) @(negedge mclk);
      chk("edges at match", 16'h0001, 16'(irqBCnt - cnt));
      wr(TDC_ADDR_MODE_B, 8'h00);
    end
    // A high port latch must reach both pins whatever the timer does
    p3Latch = 1'h1;
    p9Latch = 1'h1;
    repeat (2) @(negedge mclk);
    chk("pin3 latch", 16'h0001, {15'h0000, p3Out});
    chk("pin9 latch", 16'h0001, {15'h0000, p9Out});
    chk("pin3 enable", 16'h0001, {15'h0000, p3Oe});
    chk("port9Dir", 16'h0058, {8'h00, port9Dir});
    p3Latch = 1'h0;
    p9Latch = 1'h0;
    wr(TDC_ADDR_CLKSEL_A, 8'h02);
    wr(TDC_ADDR_COMPARE_A, 8'h40);
    for (int i = 0; i < 2; i++) begin
      wr(TDC_ADDR_MODE_A, 8'h00);
      wr(TDC_ADDR_MODE_A, 8'hc1 | 8'(i << 1));
      repeat (16) @(negedge mclk);
      cnt = 0;
      repeat (2048) @(negedge mclk) if (p3Out === 1'h1) cnt++;
      chk("pwm high time", (i == 1) ? 16'd1536 : 16'd512, 16'(cnt));
    end
    wr(TDC_ADDR_MODE_A, 8'h00);
    wr(TDC_ADDR_COMPARE_A, 8'h01);
    wr(TDC_ADDR_COMPARE_B, 8'h01);
    wr(TDC_ADDR_MODE_B, 8'h90);
    wr(TDC_ADDR_MODE_A, 8'h80);
    wait_irq(1'h0, n);
    wait_irq(1'h0, n);
    chk("cascade interval", 16'd2064, 16'(n));
    chk("cascade irq A", 16'h0001, {15'h0000, irqA});
    final_report();
  end
endmodule
`default_nettype wire
